// ==== hw/epwm_timer.sv ====
// eight channel pwm timer with apb register access
//
// Function
// - eight channels, 8-bit period and duty
// - own counter, period, duty per channel
// - duty settable from 0 to 100 percent; 100 needs duty > period, so not with period all ones
// - software selects output polarity per channel
// - left-aligned or centre-aligned per channel
// - pairs 7/6,5/4,3/2,1/0 join to 16 bits
// - joining chosen per pair independently
`timescale 1ns/1ns
module epwm_timer
    import epwm_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // waveform pins
    output logic      [7:0]  pwm_out
);

    // ********************************
    // registers
    // ********************************
    logic [7:0] enable_q, polarity_q, center_q;
    logic [3:0] join_q;
    logic [7:0] period_q [EPWM_NCH];
    logic [7:0] duty_q   [EPWM_NCH];
    logic [7:0] cnt_q    [EPWM_NCH];
    logic [7:0] down_q;
    logic [7:0] pwm_d;
    logic [31:0] prdata_d;
    logic        pslverr_d;
    epwm_req_t   req;

    assign req.addr  = paddr;
    assign req.write = pwrite;
    assign req.wdata = pwdata;

    // setup phase is the only wait; answer in the access cycle
    wire setup_w = psel & ~penable;
    wire wr_w    = psel & penable & pready & req.write;

    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        in_bank = (a >= base) && (a < base + 8'h20) && (a[1:0] == 2'b00);
    endfunction

    wire [2:0] idx_w     = req.addr[4:2];
    wire       hit_per_w = in_bank(req.addr, EPWM_OFF_PERIOD0);
    wire       hit_dut_w = in_bank(req.addr, EPWM_OFF_DUTY0);
    wire       hit_cnt_w = in_bank(req.addr, EPWM_OFF_COUNT0);

    // ********************************
    // apb slave
    // ********************************
    always_comb begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (hit_per_w) begin
            prdata_d[7:0] = period_q[idx_w];
        end else if (hit_dut_w) begin
            prdata_d[7:0] = duty_q[idx_w];
        end else if (hit_cnt_w) begin
            prdata_d[7:0] = cnt_q[idx_w];
        end else begin
            unique case (req.addr)
                EPWM_OFF_ENABLE:   prdata_d[7:0] = enable_q;
                EPWM_OFF_POLARITY: prdata_d[7:0] = polarity_q;
                EPWM_OFF_CENTER:   prdata_d[7:0] = center_q;
                EPWM_OFF_JOIN:     prdata_d[3:0] = join_q;
                EPWM_OFF_OUTPUT:   prdata_d[7:0] = pwm_out;
                default:           pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_w;
            prdata  <= setup_w ? prdata_d : 32'h0000_0000;
            pslverr <= setup_w & pslverr_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q   <= EPWM_RST_CTRL;
            polarity_q <= EPWM_RST_CTRL;
            center_q   <= EPWM_RST_CTRL;
            join_q     <= 4'h0;
        end else if (wr_w) begin
            if (req.addr == EPWM_OFF_ENABLE)   enable_q   <= req.wdata[7:0];
            if (req.addr == EPWM_OFF_POLARITY) polarity_q <= req.wdata[7:0];
            if (req.addr == EPWM_OFF_CENTER)   center_q   <= req.wdata[7:0];
            if (req.addr == EPWM_OFF_JOIN)     join_q     <= req.wdata[3:0];
        end
    end

    // ********************************
    // channels
    // ********************************
    // joined pair: odd channel is high byte, even low; the odd channel's
    // enable, centre bit and pin govern, each pin keeps its own polarity bit, the even pin holds idle
    genvar g;
    generate
        for (g = 0; g < EPWM_NCH; g++) begin : g_ch
            localparam int P = g / 2;
            localparam int E = g & ~1;
            localparam int O = g | 1;
            wire        joined = join_q[P];
            wire        odd    = (g % 2) == 1;
            wire        en     = enable_q[joined ? O : g];
            wire        ctr    = center_q[joined ? O : g];
            wire        pol    = polarity_q[g];
            wire [15:0] per    = joined ? {period_q[O], period_q[E]} : {8'h00, period_q[g]};
            wire [15:0] dut    = joined ? {duty_q[O], duty_q[E]} : {8'h00, duty_q[g]};
            wire [15:0] cnt    = joined ? {cnt_q[O], cnt_q[E]} : {8'h00, cnt_q[g]};
            wire        dn     = down_q[joined ? O : g];
            wire        top    = cnt >= per;
            wire        bot    = cnt == 16'h0000;
            // next counter: left wraps at period, centre bounces 0..period
            wire [15:0] nxt    = !ctr ? (top ? 16'h0000 : cnt + 16'h0001)
                               : (dn ? (bot ? 16'h0001 : cnt - 16'h0001)
                                     : (top ? cnt - 16'h0001 : cnt + 16'h0001));
            wire        ndn    = ctr & (dn ? ~bot : top);
            // active while count below duty: duty 0 never, duty > period always
            wire        act    = cnt < dut;
            wire        drive  = (joined && !odd) ? 1'b0 : en & act;

            assign pwm_d[g] = pol ? drive : ~drive;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    period_q[g] <= EPWM_RST_PER;
                    duty_q[g]   <= EPWM_RST_DUTY;
                    cnt_q[g]    <= 8'h00;
                    down_q[g]   <= 1'b0;
                end else begin
                    if (wr_w && hit_per_w && idx_w == g) period_q[g] <= req.wdata[7:0];
                    if (wr_w && hit_dut_w && idx_w == g) duty_q[g]   <= req.wdata[7:0];
                    if (!en) begin
                        cnt_q[g]  <= 8'h00;
                        down_q[g] <= 1'b0;
                    end else begin
                        cnt_q[g]  <= (joined && odd) ? nxt[15:8] : nxt[7:0];
                        down_q[g] <= ndn;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 8'h00;
        end else begin
            pwm_out <= pwm_d;
        end
    end

endmodule

// ==== shared/epwm_pkg.sv ====
// package of constants and types for the eight channel pwm timer
package epwm_pkg;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] EPWM_OFF_ENABLE   = 8'h00;
    localparam logic [7:0] EPWM_OFF_POLARITY = 8'h04;
    localparam logic [7:0] EPWM_OFF_CENTER   = 8'h08;
    localparam logic [7:0] EPWM_OFF_JOIN     = 8'h0c;
    localparam logic [7:0] EPWM_OFF_PERIOD0  = 8'h20;
    localparam logic [7:0] EPWM_OFF_DUTY0    = 8'h40;
    localparam logic [7:0] EPWM_OFF_COUNT0   = 8'h60;
    localparam logic [7:0] EPWM_OFF_OUTPUT   = 8'h80;

    // ********************************
    // reset values and sizes
    // ********************************
    localparam int         EPWM_NCH      = 8;
    localparam int         EPWM_NPAIR    = 4;
    localparam logic [7:0] EPWM_RST_CTRL = 8'h00;
    localparam logic [7:0] EPWM_RST_PER  = 8'hff;
    localparam logic [7:0] EPWM_RST_DUTY = 8'h00;

    // apb request carrier
    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } epwm_req_t;

endpackage

// ==== verif/epwm_load.sv ====
// load model on the waveform pins: counts high cycles per pin
`timescale 1ns/1ns
module epwm_load (
    input wire logic  pclk,
    input wire logic  clr,
    input wire logic  [7:0] pin,
    output logic      [15:0] high_cnt [8]
);
    always_ff @(posedge pclk)
        for (int i = 0; i < 8; i++) high_cnt[i] <= clr ? 16'h0 : high_cnt[i] + 16'(pin[i]);
endmodule

// ==== verif/epwm_timer_assertions.sv ====
// concurrent checks on the apb port of the pwm timer
`timescale 1ns/1ns
module epwm_timer_assertions
    import epwm_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    a_setup_ready: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready too long");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_err_unmapped: assert property (s_setup ##0 (paddr == 8'hfc) |=> pslverr)
        else $error("unmapped not refused");
    a_err_mapped: assert property (s_setup ##0 (paddr == EPWM_OFF_ENABLE) |=> !pslverr)
        else $error("mapped refused");
    a_err_pulse: assert property (pslverr |-> pready)
        else $error("error off access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("data off access");
    a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper data bits set");
    a_join_width: assert property (s_setup ##0 (!pwrite && paddr == EPWM_OFF_JOIN)
        |=> prdata[7:4] == 4'h0) else $error("join beyond four pairs");
endmodule
bind epwm_timer epwm_timer_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr);

// ==== verif/testbench.sv ====
// register and waveform tests of the pwm timer
`timescale 1ns/1ns
module testbench
    import epwm_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 1;
    logic [7:0] paddr = 8'h0, pwm_out;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e;
    logic [15:0] hcnt [8];
    int errors = 0, checks = 0, cyc = 0;
    // odd pair 7/6 joined: period 0x012b gives 300 cycles, a multiple of every other period
    logic [7:0][7:0] per = 64'h012b050509090909, dut = 64'h0096020203ff0003;
    logic [7:0][15:0] hexp = {16'd150, 16'd0, 16'd100, 16'd90, 16'd210, 16'd300, 16'd0, 16'd90};
    epwm_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pwm_out);
    epwm_load i_load (.pclk, .clr, .pin(pwm_out), .high_cnt(hcnt));
    always #10 pclk = ~pclk;
    task automatic end_of_test();
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk("rdata", r, exp);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        #1 chk("idle pins", 32'(pwm_out), 32'hff);
        rd(EPWM_OFF_ENABLE, 32'h0);
        rd(EPWM_OFF_PERIOD0 + 8'h1c, 32'hff);
        rd(EPWM_OFF_COUNT0, 32'h0);
        rd(EPWM_OFF_OUTPUT, 32'hff);
        apb(1, 8'hfc, 32'hff);
        chk("unmapped err", 32'(e), 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1, EPWM_OFF_PERIOD0 + 8'(4 * i), 32'(per[i]));
            apb(1, EPWM_OFF_DUTY0 + 8'(4 * i), 32'(dut[i]));
            rd(EPWM_OFF_PERIOD0 + 8'(4 * i), 32'(per[i]));
            rd(EPWM_OFF_DUTY0 + 8'(4 * i), 32'(dut[i]));
        end
        apb(1, EPWM_OFF_POLARITY, 32'hf7);
        rd(EPWM_OFF_POLARITY, 32'hf7);
        apb(1, EPWM_OFF_CENTER, 32'h10);
        rd(EPWM_OFF_CENTER, 32'h10);
        apb(1, EPWM_OFF_JOIN, 32'hff);
        rd(EPWM_OFF_JOIN, 32'h0f);
        apb(1, EPWM_OFF_JOIN, 32'h08);
        apb(1, EPWM_OFF_ENABLE, 32'hff);
        repeat (4) @(posedge pclk);
        clr <= 0;
        repeat (300) @(posedge pclk);
        #1 for (int i = 0; i < 8; i++) chk("high cycles", 32'(hcnt[i]), 32'(hexp[i]));
        chk("centre cycles", 32'(hcnt[4]), 32'd90);
        chk("left cycles", 32'(hcnt[5]), 32'd100);
        chk("pair 3 cycles", 32'(hcnt[7]), 32'd150);
        chk("pair 3 even pin", 32'(hcnt[6]), 32'd0);
        end_of_test();
    end
endmodule
